// ---- include/irxcm_pkg.sv ----
package irxcm_pkg;
  localparam int unsigned MASK_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] SET_OFFSET = 8'h78;
  localparam logic [7:0] CLEAR_OFFSET = 8'h7C;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
endpackage

// ---- rtl/irxcm_iso_rx_channel_mask_low.sv ----
// Function
// R01: Hold 32-bit mask for channels 0 to 31
// R02: Write one at 78h sets mask bits
// R03: Write one at 7Ch clears mask bits
// R04: Mask bit n enables channel n
// R05: Read at either address returns mask unchanged
// R06: Mask undefined after reset; software initialises
//
// Chosen here: the Wishbone interface to the registers.
module irxcm_iso_rx_channel_mask_low (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [irxcm_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [irxcm_pkg::MASK_W-1:0] wb_dat_i,
  output logic [irxcm_pkg::MASK_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [irxcm_pkg::MASK_W-1:0] rx_chan_enable
);
  import irxcm_pkg::*;

  localparam int unsigned LANES = MASK_W / 8;

  logic req;
  logic wr_req;
  logic rd_req;
  logic hit_set;
  logic hit_clr;
  logic hit_any;
  logic [MASK_W-1:0] lane_mask;
  logic [MASK_W-1:0] set_strobe;
  logic [MASK_W-1:0] clr_strobe;

  logic [MASK_W-1:0] mask_q;
  logic [MASK_W-1:0] mask_d;

  // Bits written since reset; only the checks below read them
  logic [MASK_W-1:0] known_q;
  logic [MASK_W-1:0] known_d;

  logic ack_q;
  logic ack_d;
  logic [MASK_W-1:0] rdat_q;
  logic [MASK_W-1:0] rdat_d;

  logic rx_chan_enable_bit_0;
  logic rx_chan_enable_bit_31;

  // Blocking on ack_q keeps a held strobe from being taken twice in a row
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_req = req && wb_we_i;
  assign rd_req = req && !wb_we_i;
  assign hit_set = (wb_adr_i == SET_OFFSET);
  assign hit_clr = (wb_adr_i == CLEAR_OFFSET);
  assign hit_any = hit_set || hit_clr;

  // Byte enables widened to one bit per mask bit
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // One set and one clear strobe per channel
  genvar gn;
  generate
    for (gn = 0; gn < MASK_W; gn++) begin : g_chan
      assign set_strobe[gn] = wr_req && hit_set && wb_dat_i[gn] && lane_mask[gn]; // R02
      assign clr_strobe[gn] = wr_req && hit_clr && wb_dat_i[gn] && lane_mask[gn]; // R03

      chan_on_a: assert property (@(posedge clk_sys) disable iff (rst) // R04
        set_strobe[gn] |=> rx_chan_enable[gn])
        else $error("set write did not enable its channel");

      chan_off_a: assert property (@(posedge clk_sys) disable iff (rst) // R04
        clr_strobe[gn] |=> !rx_chan_enable[gn])
        else $error("clear write did not disable its channel");
    end
  endgenerate

  // Set and clear sit at different addresses, so their strobes never meet
  always_comb begin
    mask_d = (mask_q | set_strobe) & ~clr_strobe; // R02 R03
  end

  // No reset on purpose: the mask stays undefined until software writes it
  always_ff @(posedge clk_sys) begin
    mask_q <= mask_d; // R01 R06
  end

  always_comb begin
    known_d = known_q | set_strobe | clr_strobe;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      known_q <= '0;
    end else begin
      known_q <= known_d;
    end
  end

  // Reads ignore the byte enables
  always_comb begin
    ack_d = req;
    rdat_d = rdat_q;
    if (rd_req) begin
      rdat_d = hit_any ? mask_q : UNMAPPED_READ; // R05
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= MASK_RESET;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign rx_chan_enable = mask_q; // R04
  assign rx_chan_enable_bit_0 = rx_chan_enable[0]; // R04
  assign rx_chan_enable_bit_31 = rx_chan_enable[31]; // R04

  // Mask update checks; unwritten bits are masked off by known_q
  set_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // R02
    (wr_req && hit_set && wb_sel_i == 4'hF)
    |=> ((mask_q & $past(wb_dat_i)) == $past(wb_dat_i)))
    else $error("set write did not set bits");

  clear_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // R03
    (wr_req && hit_clr && wb_sel_i == 4'hF)
    |=> ((mask_q & $past(wb_dat_i)) == '0))
    else $error("clear write did not clear bits");

  keep_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // R02
    (wr_req && hit_set)
    |=> (((mask_q ^ $past(mask_q)) & $past(known_q) & ~$past(wb_dat_i & lane_mask)) == '0))
    else $error("set write changed zero bits");

  clear_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // R03
    (wr_req && hit_clr)
    |=> (((mask_q ^ $past(mask_q)) & $past(known_q) & ~$past(wb_dat_i & lane_mask)) == '0))
    else $error("clear write changed zero bits");

  lane_off_a: assert property (@(posedge clk_sys) disable iff (rst) // R02 R03
    (wr_req && wb_sel_i == 4'h0)
    |=> (((mask_q ^ $past(mask_q)) & $past(known_q)) == '0))
    else $error("write with no lanes changed mask");

  unmapped_write_a: assert property (@(posedge clk_sys) disable iff (rst) // R01
    (wr_req && !hit_any)
    |=> (((mask_q ^ $past(mask_q)) & $past(known_q)) == '0))
    else $error("unmapped write changed mask");

  idle_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R01
    !wr_req
    |=> (((mask_q ^ $past(mask_q)) & $past(known_q)) == '0))
    else $error("mask changed without write");

  chan_low_a: assert property (@(posedge clk_sys) disable iff (rst) // R04
    set_strobe[0]
    |=> rx_chan_enable_bit_0)
    else $error("channel 0 not enabled by bit 0");

  chan_high_a: assert property (@(posedge clk_sys) disable iff (rst) // R04
    clr_strobe[31]
    |=> !rx_chan_enable_bit_31)
    else $error("channel 31 not disabled by bit 31");

  // Read path checks
  read_data_a: assert property (@(posedge clk_sys) disable iff (rst) // R05
    (rd_req && hit_any)
    |=> (wb_ack_o && (((wb_dat_o ^ $past(mask_q)) & $past(known_q)) == '0)))
    else $error("read did not return mask");

  read_stable_a: assert property (@(posedge clk_sys) disable iff (rst) // R05
    rd_req
    |=> (((mask_q ^ $past(mask_q)) & $past(known_q)) == '0))
    else $error("read altered mask");

  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_req && !hit_any)
    |=> (wb_dat_o == UNMAPPED_READ))
    else $error("unmapped read returned wrong data");

  // Bus handshake checks
  ack_once_a: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o
    |=> !wb_ack_o)
    else $error("ack held two cycles");

  ack_timing_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> wb_ack_o)
    else $error("ack not given after one cycle");

  ack_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o
    |-> $past(req))
    else $error("ack without a taken request");

  reset_out_a: assert property (@(posedge clk_sys)
    rst
    |=> (!wb_ack_o && wb_dat_o == MASK_RESET))
    else $error("bus outputs not cleared by reset");

  // Main scenarios
  set_cov_c: cover property (@(posedge clk_sys)
    wr_req && hit_set);
  clr_cov_c: cover property (@(posedge clk_sys)
    wr_req && hit_clr);
  rd_cov_c: cover property (@(posedge clk_sys)
    rd_req && hit_clr);
  bad_cov_c: cover property (@(posedge clk_sys)
    req && !hit_any);
  lane_cov_c: cover property (@(posedge clk_sys)
    wr_req && hit_any && wb_sel_i != 4'hF && wb_sel_i != 4'h0);
endmodule // irxcm_iso_rx_channel_mask_low

// ---- testbench/tb_iso_rx_channel_mask_low.sv ----
module tb_iso_rx_channel_mask_low;
  timeunit 1ns;
  timeprecision 1ps;
  import irxcm_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, a;
  logic [3:0] sel = 4'hF, s;
  logic [31:0] wd = 32'h0, rd, en, m, d, x;
  int errors = 0, total_checks = 0, op;
  always #12.5 clk_sys = ~clk_sys;
  irxcm_iso_rx_channel_mask_low irxcm_iso_rx_channel_mask_low_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_cyc_i(cyc),
    .wb_stb_i(cyc),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wd),
    .wb_dat_o(rd),
    .wb_ack_o(ack),
    .rx_chan_enable(en)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // Mask after one write: code 0 sets, 1 clears, anything else leaves it
  function automatic logic [31:0] next_mask(input int code, input logic [31:0] cur,
      input logic [31:0] data, input logic [3:0] lanes);
    logic [31:0] hit;
    hit = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}} & data;
    if (code == 0) return cur | hit;
    if (code == 1) return cur & ~hit;
    return cur;
  endfunction
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt,
      input logic [3:0] sl);
    cyc <= 1'b1; we <= w; adr <= ad; wd <= dt; sel <= sl;
    do @(posedge clk_sys); while (ack !== 1'b1);
    d = rd;
    cyc <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    results();
  end
  initial begin
    void'($urandom(27951));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    chk({31'h0, ack}, 32'h0);
    chk(rd, MASK_RESET);
    // Mask has no reset value, so force it to a known state first
    bus(1, SET_OFFSET, 32'hFFFF_FFFF, 4'hF);
    bus(1, CLEAR_OFFSET, 32'hFFFF_FFFF, 4'hF);
    m = 32'h0;
    for (int i = 0; i < 60; i++) begin
      x = (i < 2) ? 32'h8000_0001 : $urandom;
      s = (i < 2) ? 4'hF : 4'($urandom);
      op = (i < 2) ? i : $urandom_range(2);
      a = (op == 0) ? SET_OFFSET : (op == 1) ? CLEAR_OFFSET : 8'h70;
      m = next_mask(op, m, x, s);
      bus(1, a, x, s);
      chk(en, m);
      bus(0, i[0] ? SET_OFFSET : CLEAR_OFFSET, ~x, 4'h0);
      chk(d, m);
      chk(en, m);
    end
    bus(0, 8'h74, 32'h0, 4'hF);
    chk(d, UNMAPPED_READ);
    results();
  end
endmodule // tb_iso_rx_channel_mask_low
